/* File: hdl/pfl_pkg.sv */
// constants and types for the peripheral interrupt flag block
`default_nettype none
package pfl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // data memory addressing
   localparam int unsigned PFL_ADDR_W  = 12;
   localparam int unsigned PFL_BANK_W  = 5;
   localparam int unsigned PFL_OFS_W   = 7;
   localparam int unsigned PFL_DATA_W  = 8;

   localparam logic [6:0] PFL_OFS_CORE_CTRL = 7'h0b;
   localparam logic [4:0] PFL_BANK_REQ      = 5'h00;
   localparam logic [6:0] PFL_OFS_REQ_TWO   = 7'h12;
   localparam logic [6:0] PFL_OFS_REQ_THREE = 7'h13;
   localparam logic [4:0] PFL_BANK_ENA      = 5'h01;
   localparam logic [6:0] PFL_OFS_ENA_TWO   = 7'h12;
   localparam logic [6:0] PFL_OFS_ENA_THREE = 7'h13;

   ////////////////////////////////////////////////////////////////////////////
   // core interrupt control bit positions
   localparam int unsigned PFL_CC_GLOBAL_EN = 7;
   localparam int unsigned PFL_CC_PERIPH_EN = 6;
   localparam int unsigned PFL_CC_T0_EN     = 5;
   localparam int unsigned PFL_CC_EXT_EN    = 4;
   localparam int unsigned PFL_CC_IOC_EN    = 3;
   localparam int unsigned PFL_CC_T0_FLAG   = 2;
   localparam int unsigned PFL_CC_EXT_FLAG  = 1;
   localparam int unsigned PFL_CC_IOC_FLAG  = 0;

   // peripheral bank two bit positions
   localparam int unsigned PFL_P2_ADC  = 6;
   localparam int unsigned PFL_P2_BCL1 = 3;
   localparam int unsigned PFL_P2_BCL2 = 2;
   localparam int unsigned PFL_P2_TMR4 = 1;

   ////////////////////////////////////////////////////////////////////////////
   // masks and reset values
   localparam logic [7:0] PFL_MASK_TWO   = 8'h4e;
   localparam logic [7:0] PFL_MASK_THREE = 8'hff;
   localparam logic [7:0] PFL_RST_REG    = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [0:0] {
      PFL_RUN = 1'b0,
      PFL_ISR = 1'b1
   } pfl_isr_e;

   typedef struct packed {
      logic       timer0_overflow;
      logic       ext_pin;
      logic       pin_change_level;
      logic       adc;
      logic       bus_collision_one;
      logic       bus_collision_two;
      logic       timer4_match_two;
      logic [7:0] req_three;
   } pfl_event_s;

   typedef struct packed {
      logic [7:0] wreg;
      logic [7:0] status;
      logic [4:0] bank_sel;
      logic [6:0] pc_latch;
      logic [7:0] fsr0_lo;
      logic [7:0] fsr0_hi;
      logic [7:0] fsr1_lo;
      logic [7:0] fsr1_hi;
   } pfl_ctx_s;

endpackage : pfl_pkg
`default_nettype wire

/* File: hdl/pfl_flag_bank.sv */
// bank of flag or enable bits with software write and hardware set
`default_nettype none
module pfl_flag_bank
   import pfl_pkg::*;
#(
   parameter int unsigned W    = 8,
   parameter logic [7:0]  MASK = 8'hff
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   // software write
   input  wire logic         wr_en,
   input  wire logic [W-1:0] wr_data,
   // hardware set
   input  wire logic [W-1:0] set,
   // stored bits
   output logic      [W-1:0] q
);

   // refuse widths the eight bit mask cannot cover
   if (W < 1 || W > 8) begin : g_bad_width
      $error("pfl_flag_bank width out of range");
   end

   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // per bit next value, set beats clear
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_bit
         always_comb begin
            if (!MASK[gi]) begin
               q_nxt[gi] = 1'b0;
            end else begin
               q_nxt[gi] = (wr_en ? wr_data[gi] : q_r[gi]) | set[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q_r <= PFL_RST_REG[W-1:0];
      end else begin
         q_r <= q_nxt;
      end
   end

   assign q = q_r;

endmodule : pfl_flag_bank
`default_nettype wire

/* File: hdl/pfl_irq_ctrl.sv */
// interrupt flags, enables, request and context save of the core
`default_nettype none
module pfl_irq_ctrl
   import pfl_pkg::*;
(
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   // data memory access
   input  wire logic [PFL_ADDR_W-1:0] mem_addr,
   input  wire logic                  mem_wr,
   input  wire logic                  mem_rd,
   input  wire logic [PFL_DATA_W-1:0] mem_wdata,
   output logic      [PFL_DATA_W-1:0] mem_rdata,
   output logic                       mem_hit,
   // peripheral events
   input  wire pfl_event_s            events,
   // cpu handshake
   input  wire logic                  cpu_take,
   input  wire logic                  cpu_return,
   input  wire pfl_ctx_s              cpu_ctx,
   output logic                       irq_req,
   output logic                       ctx_restore,
   output pfl_ctx_s                   ctx_shadow
);

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   logic [PFL_BANK_W-1:0] bank;
   logic [PFL_OFS_W-1:0]  ofs;
   logic                  sel_core;
   logic                  sel_req_two;
   logic                  sel_req_three;
   logic                  sel_ena_two;
   logic                  sel_ena_three;

   assign bank          = mem_addr[PFL_ADDR_W-1:PFL_OFS_W];
   assign ofs           = mem_addr[PFL_OFS_W-1:0];
   assign sel_core      = (ofs == PFL_OFS_CORE_CTRL);
   assign sel_req_two   = (bank == PFL_BANK_REQ) && (ofs == PFL_OFS_REQ_TWO);
   assign sel_req_three = (bank == PFL_BANK_REQ) && (ofs == PFL_OFS_REQ_THREE);
   assign sel_ena_two   = (bank == PFL_BANK_ENA) && (ofs == PFL_OFS_ENA_TWO);
   assign sel_ena_three = (bank == PFL_BANK_ENA) && (ofs == PFL_OFS_ENA_THREE);

   ////////////////////////////////////////////////////////////////////////////
   // peripheral request and enable banks
   logic [7:0] req_two;
   logic [7:0] req_three;
   logic [7:0] ena_two;
   logic [7:0] ena_three;
   logic [7:0] set_two;

   always_comb begin
      set_two              = 8'h00;
      set_two[PFL_P2_ADC]  = events.adc;
      set_two[PFL_P2_BCL1] = events.bus_collision_one;
      set_two[PFL_P2_BCL2] = events.bus_collision_two;
      set_two[PFL_P2_TMR4] = events.timer4_match_two;
   end

   pfl_flag_bank #(
      .W    (8),
      .MASK (PFL_MASK_TWO)
   ) u_req_two (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wr_en    (mem_wr && sel_req_two),
      .wr_data  (mem_wdata),
      .set      (set_two),
      .q        (req_two)
   );

   pfl_flag_bank #(
      .W    (8),
      .MASK (PFL_MASK_THREE)
   ) u_req_three (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wr_en    (mem_wr && sel_req_three),
      .wr_data  (mem_wdata),
      .set      (events.req_three),
      .q        (req_three)
   );

   pfl_flag_bank #(
      .W    (8),
      .MASK (PFL_MASK_TWO)
   ) u_ena_two (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wr_en    (mem_wr && sel_ena_two),
      .wr_data  (mem_wdata),
      .set      (8'h00),
      .q        (ena_two)
   );

   pfl_flag_bank #(
      .W    (8),
      .MASK (PFL_MASK_THREE)
   ) u_ena_three (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wr_en    (mem_wr && sel_ena_three),
      .wr_data  (mem_wdata),
      .set      (8'h00),
      .q        (ena_three)
   );

   ////////////////////////////////////////////////////////////////////////////
   // core interrupt control register
   logic [7:0] core_ctrl_r;
   logic [7:0] core_ctrl_nxt;
   logic [7:0] core_ctrl_view;

   always_comb begin
      core_ctrl_nxt = core_ctrl_r;
      if (mem_wr && sel_core) begin
         core_ctrl_nxt = mem_wdata;
      end
      // hardware sets win over software clears
      core_ctrl_nxt[PFL_CC_T0_FLAG]  = core_ctrl_nxt[PFL_CC_T0_FLAG] | events.timer0_overflow;
      core_ctrl_nxt[PFL_CC_EXT_FLAG] = core_ctrl_nxt[PFL_CC_EXT_FLAG] | events.ext_pin;
      core_ctrl_nxt[PFL_CC_IOC_FLAG] = 1'b0;
      if (cpu_take) begin
         core_ctrl_nxt[PFL_CC_GLOBAL_EN] = 1'b0;
      end else if (cpu_return) begin
         core_ctrl_nxt[PFL_CC_GLOBAL_EN] = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         core_ctrl_r <= PFL_RST_REG;
      end else begin
         core_ctrl_r <= core_ctrl_nxt;
      end
   end

   // pin change flag mirrors the pin change level
   always_comb begin
      core_ctrl_view                  = core_ctrl_r;
      core_ctrl_view[PFL_CC_IOC_FLAG] = events.pin_change_level;
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt request
   logic irq_req_r;
   logic irq_req_nxt;
   logic core_pending;
   logic periph_pending;

   always_comb begin
      core_pending = (core_ctrl_r[PFL_CC_T0_EN] && core_ctrl_r[PFL_CC_T0_FLAG])
                   || (core_ctrl_r[PFL_CC_EXT_EN] && core_ctrl_r[PFL_CC_EXT_FLAG])
                   || (core_ctrl_r[PFL_CC_IOC_EN] && events.pin_change_level);
      periph_pending = core_ctrl_r[PFL_CC_PERIPH_EN]
                     && ((|(ena_two & req_two)) || (|(ena_three & req_three)));
      irq_req_nxt = core_ctrl_r[PFL_CC_GLOBAL_EN] && (core_pending || periph_pending);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_req_r <= 1'b0;
      end else begin
         irq_req_r <= irq_req_nxt;
      end
   end

   assign irq_req = irq_req_r;

   ////////////////////////////////////////////////////////////////////////////
   // context save and restore
   pfl_isr_e isr_r;
   pfl_isr_e isr_nxt;
   pfl_ctx_s shadow_r;
   pfl_ctx_s shadow_nxt;
   logic     restore_r;
   logic     restore_nxt;

   always_comb begin
      isr_nxt     = isr_r;
      shadow_nxt  = shadow_r;
      restore_nxt = 1'b0;
      unique case (isr_r)
         PFL_RUN: begin
            if (cpu_take) begin
               shadow_nxt = cpu_ctx;
               isr_nxt    = PFL_ISR;
            end
         end
         PFL_ISR: begin
            if (cpu_return) begin
               restore_nxt = 1'b1;
               isr_nxt     = PFL_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         isr_r     <= PFL_RUN;
         shadow_r  <= '0;
         restore_r <= 1'b0;
      end else begin
         isr_r     <= isr_nxt;
         shadow_r  <= shadow_nxt;
         restore_r <= restore_nxt;
      end
   end

   assign ctx_restore = restore_r;
   assign ctx_shadow  = shadow_r;

   ////////////////////////////////////////////////////////////////////////////
   // read data
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       hit_r;
   logic       hit_nxt;

   always_comb begin
      rdata_nxt = 8'h00;
      hit_nxt   = 1'b0;
      if (mem_rd) begin
         hit_nxt = 1'b1;
         if (sel_core) begin
            rdata_nxt = core_ctrl_view;
         end else if (sel_req_two) begin
            rdata_nxt = req_two;
         end else if (sel_req_three) begin
            rdata_nxt = req_three;
         end else if (sel_ena_two) begin
            rdata_nxt = ena_two;
         end else if (sel_ena_three) begin
            rdata_nxt = ena_three;
         end else begin
            hit_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
         hit_r   <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         hit_r   <= hit_nxt;
      end
   end

   assign mem_rdata = rdata_r;
   assign mem_hit   = hit_r;

endmodule : pfl_irq_ctrl
`default_nettype wire

/* File: verif/pfl_irq_ctrl_chk.sv */
// assertion checker for the interrupt flag block
`default_nettype none
module pfl_irq_ctrl_chk
   import pfl_pkg::*;
(
   // clock and reset
   input wire logic                  core_clk,
   input wire logic                  rst_n,
   // data memory access
   input wire logic [PFL_ADDR_W-1:0] mem_addr,
   input wire logic                  mem_wr,
   input wire logic                  mem_rd,
   input wire logic [PFL_DATA_W-1:0] mem_wdata,
   input wire logic [PFL_DATA_W-1:0] mem_rdata,
   input wire logic                  mem_hit,
   // events and cpu
   input wire pfl_event_s            events,
   input wire logic                  cpu_take,
   input wire logic                  cpu_return,
   input wire pfl_ctx_s              cpu_ctx,
   input wire logic                  irq_req,
   input wire logic                  ctx_restore,
   input wire pfl_ctx_s              ctx_shadow
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////
   // service routine tracking
   logic isr_r;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         isr_r <= 1'b0;
      end else if (isr_r) begin
         isr_r <= !cpu_return;
      end else begin
         isr_r <= cpu_take;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // properties
   property p_ctrl_hit;
      mem_rd && mem_addr[6:0] == PFL_OFS_CORE_CTRL |=> mem_hit;
   endproperty
   a_ctrl_hit: assert property (p_ctrl_hit) else $error("control read missed");
   property p_idle_zero;
      !mem_rd |=> mem_rdata == 8'h00 && !mem_hit;
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("read data without read");
   property p_req3_set;
      events.req_three != 8'h00 ##3 mem_rd && !mem_wr && mem_addr == 12'h013
      |=> (mem_rdata & $past(events.req_three, 4)) == $past(events.req_three, 4);
   endproperty
   a_req3_set: assert property (p_req3_set) else $error("request three bit lost");
   property p_adc_set;
      events.adc ##3 mem_rd && !mem_wr && mem_addr == 12'h012 |=> mem_rdata[PFL_P2_ADC];
   endproperty
   a_adc_set: assert property (p_adc_set) else $error("adc flag lost");
   property p_shadow;
      cpu_take && !isr_r |=> ctx_shadow == $past(cpu_ctx);
   endproperty
   a_shadow: assert property (p_shadow) else $error("context not saved");
   property p_restore;
      cpu_return && isr_r && !cpu_take |=> ctx_restore;
   endproperty
   a_restore: assert property (p_restore) else $error("restore missing");
   property p_restore_only;
      !(cpu_return && isr_r) |=> !ctx_restore;
   endproperty
   a_restore_only: assert property (p_restore_only) else $error("spurious restore");
   property p_take_drop;
      cpu_take ##1 !cpu_return |=> !irq_req;
   endproperty
   a_take_drop: assert property (p_take_drop) else $error("request after take");
   c_take: cover property (cpu_take && !isr_r);
   c_restore: cover property (ctx_restore);
   c_irq: cover property ($rose(irq_req));
endmodule : pfl_irq_ctrl_chk
`default_nettype wire

/* File: verif/pfl_far_model.sv */
// peripherals and cpu core driving the interrupt block
`default_nettype none
module pfl_far_model
   import pfl_pkg::*;
(
   // clock and bench commands
   input  wire logic       core_clk,
   input  wire pfl_event_s ev_cmd,
   input  wire logic       take_cmd,
   input  wire logic       ret_cmd,
   // toward the block
   output var pfl_event_s  events,
   output var logic        cpu_take,
   output var logic        cpu_return,
   output var pfl_ctx_s    cpu_ctx
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      events = '0;
      cpu_take = 1'b0;
      cpu_return = 1'b0;
      cpu_ctx = '0;
   end
   // commands follow one cycle later for as long as held; context pattern moves every cycle
   always @(posedge core_clk) begin
      events     <= ev_cmd;
      cpu_take   <= take_cmd;
      cpu_return <= ret_cmd;
      cpu_ctx    <= {cpu_ctx[$bits(pfl_ctx_s)-2:0], ~cpu_ctx[$bits(pfl_ctx_s)-1]};
   end
endmodule : pfl_far_model
`default_nettype wire

/* File: verif/test_peripheral_interrupt_flags.sv */
// testbench for the interrupt flag block
`default_nettype none
module test_peripheral_interrupt_flags
   import pfl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic                  core_clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic [PFL_ADDR_W-1:0] mem_addr = '0;
   logic                  mem_wr = 1'b0, mem_rd = 1'b0, take_cmd = 1'b0, ret_cmd = 1'b0;
   logic [PFL_DATA_W-1:0] mem_wdata = '0, mem_rdata;
   logic                  mem_hit, irq_req, ctx_restore, cpu_take, cpu_return;
   pfl_event_s            events, ev, ev_cmd = '0;
   pfl_ctx_s              cpu_ctx, ctx_shadow, ctx_exp;
   int                    miscompares = 0, checked = 0;
   always #50 core_clk = ~core_clk;
   pfl_irq_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n), .mem_addr(mem_addr),
      .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_hit(mem_hit), .events(events), .cpu_take(cpu_take), .cpu_return(cpu_return),
      .cpu_ctx(cpu_ctx), .irq_req(irq_req), .ctx_restore(ctx_restore),
      .ctx_shadow(ctx_shadow));
   pfl_far_model u_far (.core_clk(core_clk), .ev_cmd(ev_cmd), .take_cmd(take_cmd),
      .ret_cmd(ret_cmd), .events(events), .cpu_take(cpu_take), .cpu_return(cpu_return),
      .cpu_ctx(cpu_ctx));
   ////////////////////////////////////////////////////////////////////////////
   // tasks
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk);
      mem_addr  <= a;
      mem_wdata <= d;
      mem_wr    <= 1'b1;
      @(posedge core_clk);
      mem_wr    <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] d, input logic h);
      @(posedge core_clk);
      mem_addr <= a;
      mem_rd   <= 1'b1;
      @(posedge core_clk);
      mem_rd   <= 1'b0;
      #1;
      check(mem_rdata, d);
      check(mem_hit, h);
   endtask : rd_chk
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : idle
   task automatic fire(input pfl_event_s e);
      @(posedge core_clk);
      ev_cmd <= e;
      @(posedge core_clk);
      ev_cmd <= '0;
      idle(2);
   endtask : fire
   task automatic stop_test;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////////////////
   // tests
   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      rd_chk(12'h00b, 8'h00, 1'b1);
      rd_chk(12'h014, 8'h00, 1'b0);
      wr(12'h38b, 8'h39);
      rd_chk(12'hf8b, 8'h38, 1'b1);
      wr(12'h00b, 8'h00);
      $display("bank decode test done");
      for (int i = 0; i < 8; i++) begin
         ev = '0;
         ev.req_three = 8'h01 << i;
         fire(ev);
         rd_chk(12'h013, 8'hff >> (7 - i), 1'b1);
      end
      ev = '0;
      {ev.adc, ev.bus_collision_one, ev.bus_collision_two, ev.timer4_match_two} = 4'hf;
      fire(ev);
      check(irq_req, 1'b0);
      rd_chk(12'h012, PFL_MASK_TWO, 1'b1);
      wr(12'h012, 8'h00);
      wr(12'h013, 8'h00);
      rd_chk(12'h013, 8'h00, 1'b1);
      wr(12'h092, 8'hff);
      rd_chk(12'h092, PFL_MASK_TWO, 1'b1);
      $display("flag test done");
      wr(12'h00b, 8'h80);
      ev = '0;
      ev.adc = 1'b1;
      fire(ev);
      check(irq_req, 1'b0);
      wr(12'h00b, 8'hc0);
      idle(2);
      check(irq_req, 1'b1);
      @(posedge core_clk);
      take_cmd <= 1'b1;
      @(posedge core_clk);
      take_cmd <= 1'b0;
      @(posedge core_clk);
      ctx_exp = cpu_ctx;
      idle(2);
      check(ctx_shadow, ctx_exp);
      check(irq_req, 1'b0);
      rd_chk(12'h00b, 8'h40, 1'b1);
      @(posedge core_clk);
      ret_cmd <= 1'b1;
      @(posedge core_clk);
      ret_cmd <= 1'b0;
      idle(1);
      check(ctx_restore, 1'b1);
      idle(1);
      check(ctx_restore, 1'b0);
      check(irq_req, 1'b1);
      $display("context test done");
      wr(12'h012, 8'h00);
      wr(12'h00b, 8'ha0);
      idle(2);
      check(irq_req, 1'b0);
      ev = '0;
      ev.timer0_overflow = 1'b1;
      fire(ev);
      check(irq_req, 1'b1);
      rd_chk(12'h00b, 8'ha4, 1'b1);
      $display("timer test done");
      ev = '0;
      ev.ext_pin = 1'b1;
      fire(ev);
      rd_chk(12'h00b, 8'ha6, 1'b1);
      wr(12'h00b, 8'h88);
      idle(2);
      check(irq_req, 1'b0);
      ev = '0;
      ev.pin_change_level = 1'b1;
      @(posedge core_clk);
      ev_cmd <= ev;
      idle(3);
      check(irq_req, 1'b1);
      rd_chk(12'h00b, 8'h89, 1'b1);
      @(posedge core_clk);
      ev_cmd <= '0;
      idle(3);
      check(irq_req, 1'b0);
      $display("pin change test done");
      wr(12'h00b, 8'hc0);
      wr(12'h093, 8'h01);
      rd_chk(12'h093, 8'h01, 1'b1);
      check(irq_req, 1'b0);
      ev = '0;
      ev.req_three = 8'h01;
      fire(ev);
      check(irq_req, 1'b1);
      $display("request three enable test done");
      stop_test();
   end
   initial begin
      repeat (3000) @(posedge core_clk);
      miscompares++;
      stop_test();
   end
endmodule : test_peripheral_interrupt_flags
bind pfl_irq_ctrl pfl_irq_ctrl_chk u_chk (.core_clk(core_clk), .rst_n(rst_n),
   .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata),
   .mem_rdata(mem_rdata), .mem_hit(mem_hit), .events(events), .cpu_take(cpu_take),
   .cpu_return(cpu_return), .cpu_ctx(cpu_ctx), .irq_req(irq_req),
   .ctx_restore(ctx_restore), .ctx_shadow(ctx_shadow));
`default_nettype wire
